// *** bench/mutc_tb_top.sv ***
// Purpose: self-checking bench of the transfer controller
// Assumes: switches are taken only at reset release
// Notes:   one reset per switch setting
`default_nettype none
module mutc_tb_top
    import mutc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, unit_present = 1, bus_wr = 0, bus_rd = 0, op_en, irq;
    logic [7:0] sw = '0;
    logic [1:0] is_sys = '0, term_area;
    logic [3:0] bus_addr = '0;
    logic [31:0] bus_wdata = '0, bus_rdata, v;
    logic term_rd, term_wr, unit_rd, unit_wr, unit_bank;
    logic [AW-1:0] term_addr, unit_addr;
    logic [DW-1:0] term_wdata, unit_wdata, unit_rdata, term_rdata = '0;
    logic [2:0] phase;
    mutc_err_t err_code;
    int error_cnt = 0, compares = 0;
    logic [7:0] t_sw [8] = '{8'h00, 8'h03, 8'h02, 8'h01, 8'h19, 8'h19, 8'h91, 8'h04};
    logic [1:0] t_sys [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h3, 2'h0};
    mutc_err_t t_err [8] = '{ERR_MODE, ERR_MODE, ERR_PROTECT, ERR_PROTECT, ERR_COMPAT,
                             ERR_DATA, ERR_DATA, ERR_NONE};
    always #2.5 clk = ~clk;
    // terminal memory: four areas, words start as a pattern of area and address
    logic [DW-1:0] tmem [4][32];
    initial
    begin
        for (int r = 0; r < 4; r++)
            for (int a = 0; a < 32; a++)
                tmem[r][a] = {4'ha, 2'h0, 2'(r), 3'h0, 5'(a)};
    end
    // one-cycle read, idle line shows the inverse; writes land in their area
    always @(posedge clk)
    begin
        term_rdata <= term_rd ? tmem[term_area][term_addr] : ~term_rdata;
        if (term_wr)
            tmem[term_area][term_addr] <= term_wdata;
    end
    mutc_top dut (.clk, .rst_n, .unit_present,
        .auto_unit_to_terminal_sel(sw[IDX_AUTO_U2T]), .auto_terminal_to_unit_sel(sw[IDX_AUTO_T2U]),
        .manual_transfer_sel(sw[IDX_MANUAL]), .data_type_sel(sw[IDX_TYPE]),
        .terminal_write_enable(sw[IDX_TERM_WE]), .unit_write_enable(sw[IDX_UNIT_WE]),
        .bank_sel(sw[IDX_BANK]), .simultaneous_transfer_enable(sw[IDX_SIM]),
        .unit_bank_is_sys(is_sys), .unit_sys_compat(2'h2), .bus_addr, .bus_wdata, .bus_wr,
        .bus_rd, .bus_rdata, .term_rd, .term_wr, .term_area, .term_addr, .term_wdata,
        .term_rdata, .unit_rd, .unit_wr, .unit_bank, .unit_addr, .unit_wdata, .unit_rdata,
        .phase, .err_code, .operating_enable(op_en), .irq);
    mutc_unit_model u_unit (.clk, .rd(unit_rd), .wr(unit_wr), .bank(unit_bank),
        .addr(unit_addr), .wdata(unit_wdata), .rdata(unit_rdata));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // one register cycle; read data caught in the cycle after
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_wr <= w;
        bus_rd <= !w;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 0;
        bus_rd <= 0;
        #1 v = bus_rdata;
    endtask : bus
    // wait, bounded, for a final or waiting phase
    task automatic fin;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end
        while (!(phase inside {PH_DONE, PH_FAIL, PH_WAIT}) && n < 400);
        if (n >= 400)
            chk("phase settle", 0, 1);
    endtask : fin
    task automatic run(input logic [7:0] s, input logic [1:0] b);
        @(posedge clk);
        sw <= s;
        is_sys <= b;
        rst_n <= 0;
        repeat (5) @(posedge clk);
        rst_n <= 1;
        fin();
        chk("operating_enable", 0, op_en);
    endtask : run
    task automatic test_done;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    initial
    begin
        for (int i = 0; i < 8; i++)
        begin
            run(t_sw[i], t_sys[i]);
            chk("phase", 32'(i == 7 ? PH_WAIT : PH_FAIL), 32'(phase));
            chk("err_code", t_err[i], err_code);
            bus(0, OFF_STATUS, 0);
            chk("switches", t_sw[i], v[15:8]);
        end
        // manual start into a write-protected unit, then the fail interrupt
        bus(1, OFF_IRQ_MSK, 32'h2);
        bus(1, OFF_CTRL, 32'h7);
        fin();
        chk("manual err", ERR_PROTECT, err_code);
        repeat (3) @(posedge clk);
        #1 chk("irq", 1, irq);
        bus(1, OFF_IRQ_ST, 32'h2);
        repeat (3) @(posedge clk);
        #1 chk("irq clear", 0, irq);
        run(8'h62, 2'h0);
        chk("bank1 word0", 16'ha100, u_unit.mem[1][0]);
        chk("bank0 word0", 16'h1000, u_unit.mem[0][0]);
        chk("bank1 settings", 16'ha211, u_unit.mem[1][17]);
        run(8'ha2, 2'h0);
        chk("sys bank0", 16'ha000, u_unit.mem[0][0]);
        chk("done phase", PH_DONE, phase);
        // unit to terminal: system program from bank 1 into the system area
        run(8'h59, 2'h2);
        chk("u2t err", ERR_NONE, err_code);
        chk("term sys word0", 16'ha100, tmem[AREA_SYS][0]);
        @(posedge clk);
        unit_present <= 0;
        repeat (3) @(posedge clk);
        #1 chk("operating_enable", 1, op_en);
        test_done();
    end
    // watchdog on a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done();
    end
endmodule : mutc_tb_top
`default_nettype wire

// *** bench/mutc_unit_model.sv ***
// Purpose: behavioural memory unit with two banks behind the controller
// Assumes: read data stand in the cycle after unit_rd only
// Notes:   an idle data line shows the inverse of its last word
`default_nettype none
module mutc_unit_model
    import mutc_pkg::*;
(
    // access from the controller
    input  wire logic                    clk,
    input  wire logic                    rd,
    input  wire logic                    wr,
    input  wire logic                    bank,
    input  wire logic [mutc_pkg::AW-1:0] addr,
    input  wire logic [mutc_pkg::DW-1:0] wdata,
    // data back to the controller
    output logic      [mutc_pkg::DW-1:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DW-1:0] mem [2][32];    // bank, word
    // distinct start pattern per bank
    initial
    begin
        rdata = '0;
        for (int b = 0; b < 2; b++)
            for (int a = 0; a < 32; a++)
                mem[b][a] = DW'(16'h1000 * (b + 1) + a);
    end
    // one-cycle read; a write touches only its own bank
    always @(posedge clk)
    begin
        rdata <= rd ? mem[bank][addr] : ~rdata;
        if (wr)
            mem[bank][addr] <= wdata;
    end
endmodule : mutc_unit_model
`default_nettype wire

// *** design/mutc_pkg.sv ***
// Purpose: shared constants and types of the memory-unit transfer controller
// Assumes: single 200 MHz clock, register port with one-cycle read latency
// Notes:   offsets are byte addresses of 32-bit words
`default_nettype none
package mutc_pkg;
    localparam int         DW          = 16;        // data word width
    localparam int         AW          = 5;         // word index width
    localparam int         BA          = 4;         // register address width
    localparam logic [4:0] BANK_WORDS  = 5'h10;     // words in one bank
    localparam logic [4:0] SET_WORDS   = 5'h02;     // settings words after screen
    // register offsets
    localparam logic [3:0] OFF_CTRL    = 4'h0;
    localparam logic [3:0] OFF_STATUS  = 4'h4;
    localparam logic [3:0] OFF_IRQ_ST  = 4'h8;
    localparam logic [3:0] OFF_IRQ_MSK = 4'hc;
    // control fields (manual transfer from the touch panel)
    localparam int         CTRL_START  = 0;         // write one to start
    localparam int         CTRL_T2U    = 1;         // 1: terminal to unit
    localparam int         CTRL_BANK   = 2;
    localparam int         CTRL_SYS    = 3;         // 1: system program
    localparam int         CTRL_SIM    = 4;         // both data types, system then screen
    // captured switch positions
    localparam int         IDX_AUTO_U2T = 0;        // auto_unit_to_terminal_sel
    localparam int         IDX_AUTO_T2U = 1;        // auto_terminal_to_unit_sel
    localparam int         IDX_MANUAL   = 2;        // manual_transfer_sel
    localparam int         IDX_TYPE     = 3;        // data_type_sel
    localparam int         IDX_TERM_WE  = 4;        // terminal_write_enable
    localparam int         IDX_UNIT_WE  = 5;        // unit_write_enable
    localparam int         IDX_BANK     = 6;        // bank_sel
    localparam int         IDX_SIM      = 7;        // simultaneous_transfer_enable
    localparam logic [7:0] SW_RESET     = 8'h00;    // factory state: all off
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    localparam int         IRQ_DONE     = 0;
    localparam int         IRQ_FAIL     = 1;
    // terminal memory areas
    localparam logic [1:0] AREA_SYS    = 2'h0;
    localparam logic [1:0] AREA_SCREEN = 2'h1;
    localparam logic [1:0] AREA_SET    = 2'h2;
    // phase codes shown to software and on the phase output
    localparam logic [2:0] PH_IDLE = 3'h0;
    localparam logic [2:0] PH_PREP = 3'h1;
    localparam logic [2:0] PH_XMIT = 3'h2;
    localparam logic [2:0] PH_VER  = 3'h3;
    localparam logic [2:0] PH_DONE = 3'h4;
    localparam logic [2:0] PH_FAIL = 3'h5;
    localparam logic [2:0] PH_WAIT = 3'h6;
    typedef enum logic [2:0] {
        ERR_NONE    = 3'h0,
        ERR_MODE    = 3'h1,
        ERR_PROTECT = 3'h2,
        ERR_DATA    = 3'h3,
        ERR_COMPAT  = 3'h4,
        ERR_VERIFY  = 3'h5
    } mutc_err_t;
    typedef enum logic [2:0] {
        S_SAMPLE = 3'b000,
        S_CHECK  = 3'b001,
        S_PREP   = 3'b011,
        S_XMIT   = 3'b010,
        S_VER    = 3'b110,
        S_DONE   = 3'b111,
        S_FAIL   = 3'b101,
        S_WAIT   = 3'b100
    } mutc_state_t;
endpackage : mutc_pkg
`default_nettype wire

// *** design/mutc_top.sv ***
// Purpose: transfer controller between operator terminal and memory unit
// Assumes: switches and unit_present are synchronous; memories answer
//          a read strobe with data in the following cycle
// Notes:   one word moves every three cycles; checksum-based verify
//
// What this block does
// - sample eight switches once, use only that
// - unmodified unit reads all switches off
// - three switches select auto/auto/manual mode
// - type switch: off screen, on system
// - terminal write enable switch gates terminal writes
// - unit write enable switch gates unit writes
// - two banks; bank switch picks auto bank
// - simultaneous to unit: system bank 0, screen bank 1
// - zero or several mode switches: mode error
// - destination write disabled: protect error, no write
// - wrong data type to area: transmission error
// - terminal-to-unit overwrites target bank regardless
// - writing one bank leaves other untouched
// - no operating status while unit fitted
// - check program compatibility before system write
// - screen transfers carry settings words along
// - simultaneous read needs exactly one system bank
`default_nettype none
module mutc_top
    import mutc_pkg::*;
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // memory unit presence and switches
    input  wire logic                    unit_present,
    input  wire logic                    auto_unit_to_terminal_sel,
    input  wire logic                    auto_terminal_to_unit_sel,
    input  wire logic                    manual_transfer_sel,
    input  wire logic                    data_type_sel,
    input  wire logic                    terminal_write_enable,
    input  wire logic                    unit_write_enable,
    input  wire logic                    bank_sel,
    input  wire logic                    simultaneous_transfer_enable,
    // bank content flags from the unit
    input  wire logic [1:0]              unit_bank_is_sys,
    input  wire logic [1:0]              unit_sys_compat,
    // register port
    input  wire logic [mutc_pkg::BA-1:0] bus_addr,
    input  wire logic [31:0]             bus_wdata,
    input  wire logic                    bus_wr,
    input  wire logic                    bus_rd,
    output logic      [31:0]             bus_rdata,
    // operator terminal memory
    output logic                         term_rd,
    output logic                         term_wr,
    output logic      [1:0]              term_area,
    output logic      [mutc_pkg::AW-1:0] term_addr,
    output logic      [mutc_pkg::DW-1:0] term_wdata,
    input  wire logic [mutc_pkg::DW-1:0] term_rdata,
    // memory unit data
    output logic                         unit_rd,
    output logic                         unit_wr,
    output logic                         unit_bank,
    output logic      [mutc_pkg::AW-1:0] unit_addr,
    output logic      [mutc_pkg::DW-1:0] unit_wdata,
    input  wire logic [mutc_pkg::DW-1:0] unit_rdata,
    // status
    output logic      [2:0]              phase,
    output var mutc_pkg::mutc_err_t      err_code,
    output logic                         operating_enable,
    output logic                         irq
);
    import mutc_pkg::*;

    mutc_state_t     state;          // controller state
    logic [7:0]      sw_cap;         // switches captured at startup
    logic            c_t2u;          // direction: terminal to unit
    logic            c_sys;          // data type: system program
    logic            c_bank;         // selected bank
    logic            c_sim;          // simultaneous transfer
    logic            seg;            // segment of simultaneous transfer
    logic [AW-1:0]   idx;            // word index
    logic [1:0]      step;           // read, wait, data
    logic [DW-1:0]   xsum;           // checksum of words sent
    logic [DW-1:0]   vsum;           // checksum of words read back
    logic [DW-1:0]   rdat;           // data returning this cycle
    logic            e_sys;          // effective type for this segment
    logic            e_bank;         // effective bank for this segment
    logic [AW-1:0]   len;            // words in this segment
    logic [1:0]      e_area;         // terminal area of current word
    mutc_err_t       chk;            // result of the pre-transfer checks
    logic            done_evt;       // pulse: transfer finished
    logic            fail_evt;       // pulse: transfer failed
    logic            start_req;      // manual start written
    logic [4:0]      ctrl;           // manual transfer settings
    logic [1:0]      irq_stat;       // sticky events
    logic [1:0]      irq_mask;       // event enables

    // exactly one of the three mode switches
    function automatic logic one_mode(input logic [7:0] s);
        return (s[IDX_AUTO_U2T] + s[IDX_AUTO_T2U] + s[IDX_MANUAL]) == 2'd1;
    endfunction : one_mode

    // segment decode; simultaneous overrides type and bank switches
    always_comb
    begin
        if (c_sim)
        begin
            e_sys  = ~seg;
            e_bank = c_t2u ? seg : (seg ? ~unit_bank_is_sys[1] : unit_bank_is_sys[1]);
        end
        else
        begin
            e_sys  = c_sys;
            e_bank = c_bank;
        end
        // screen data drags the settings words along
        len    = e_sys ? BANK_WORDS : AW'(BANK_WORDS + SET_WORDS);
        e_area = e_sys ? AREA_SYS : ((idx >= BANK_WORDS) ? AREA_SET : AREA_SCREEN);
    end

    // checks made before any word moves
    always_comb
    begin
        chk = ERR_NONE;
        if (c_t2u ? !sw_cap[IDX_UNIT_WE] : !sw_cap[IDX_TERM_WE])
            chk = ERR_PROTECT;
        else if (!c_t2u && c_sim && (unit_bank_is_sys != 2'b01)
                 && (unit_bank_is_sys != 2'b10))
            chk = ERR_DATA;
        else if (!c_t2u && (unit_bank_is_sys[e_bank] != e_sys))
            chk = ERR_DATA;
        else if (!c_t2u && e_sys && !unit_sys_compat[e_bank])
            chk = ERR_COMPAT;
    end

    // data source: transmit reads the origin, verify the destination
    assign rdat = ((state == S_XMIT) == c_t2u) ? term_rdata : unit_rdata;

    // controller state machine and transfer engine
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= S_SAMPLE;
            sw_cap     <= SW_RESET;
            {c_t2u, c_sys, c_bank, c_sim, seg} <= 5'h00;
            idx        <= '0;
            step       <= 2'h0;
            xsum       <= '0;
            vsum       <= '0;
            term_rd    <= 1'b0;
            term_wr    <= 1'b0;
            term_area  <= AREA_SYS;
            term_addr  <= '0;
            term_wdata <= '0;
            unit_rd    <= 1'b0;
            unit_wr    <= 1'b0;
            unit_bank  <= 1'b0;
            unit_addr  <= '0;
            unit_wdata <= '0;
            phase      <= PH_IDLE;
            err_code   <= ERR_NONE;
            done_evt   <= 1'b0;
            fail_evt   <= 1'b0;
        end
        else
        begin
            term_rd  <= 1'b0;
            term_wr  <= 1'b0;
            unit_rd  <= 1'b0;
            unit_wr  <= 1'b0;
            done_evt <= 1'b0;
            fail_evt <= 1'b0;
            case (state)
                // single capture of the switches after reset
                S_SAMPLE:
                begin
                    sw_cap <= {simultaneous_transfer_enable, bank_sel,
                               unit_write_enable, terminal_write_enable,
                               data_type_sel, manual_transfer_sel,
                               auto_terminal_to_unit_sel, auto_unit_to_terminal_sel};
                    state  <= S_CHECK;
                end
                // mode decode from the captured pattern only
                S_CHECK:
                begin
                    if (!unit_present)
                        state <= S_DONE;                    // nothing fitted, nothing to do
                    else if (!one_mode(sw_cap))
                    begin
                        state    <= S_FAIL;
                        err_code <= ERR_MODE;
                        phase    <= PH_FAIL;
                        fail_evt <= 1'b1;
                    end
                    else if (sw_cap[IDX_MANUAL])
                    begin
                        state <= S_WAIT;
                        phase <= PH_WAIT;
                    end
                    else
                    begin
                        c_t2u  <= sw_cap[IDX_AUTO_T2U];
                        c_sys  <= sw_cap[IDX_TYPE];
                        c_bank <= sw_cap[IDX_BANK];
                        c_sim  <= sw_cap[IDX_SIM];
                        state  <= S_PREP;
                        phase  <= PH_PREP;
                    end
                end
                // manual: settings come from the touch panel
                S_WAIT:
                begin
                    if (start_req)
                    begin
                        c_t2u  <= ctrl[CTRL_T2U];
                        c_sys  <= ctrl[CTRL_SYS];
                        c_bank <= ctrl[CTRL_BANK];
                        c_sim  <= ctrl[CTRL_SIM];
                        state  <= S_PREP;
                        phase  <= PH_PREP;
                    end
                end
                // refuse before the first write if anything is wrong
                S_PREP:
                begin
                    idx  <= '0;
                    step <= 2'h0;
                    xsum <= '0;
                    vsum <= '0;
                    if (chk != ERR_NONE)
                    begin
                        state    <= S_FAIL;
                        err_code <= chk;
                        phase    <= PH_FAIL;
                        fail_evt <= 1'b1;
                    end
                    else
                    begin
                        state <= S_XMIT;
                        phase <= PH_XMIT;
                    end
                end
                // copy: read origin, wait, write destination; verify: read destination, wait, add to checksum
                S_XMIT, S_VER:
                begin
                    step <= (step == 2'h2) ? 2'h0 : step + 2'h1;
                    if (step == 2'h0)
                    begin
                        // transmit reads origin; verify reads destination
                        if ((state == S_XMIT) == c_t2u)
                            term_rd <= 1'b1;
                        else
                            unit_rd <= 1'b1;
                        term_area <= e_area;
                        term_addr <= idx;
                        unit_bank <= e_bank;
                        unit_addr <= idx;
                    end
                    else if (step == 2'h2)
                    begin
                        idx <= (idx == len - AW'(1)) ? '0 : idx + AW'(1);
                        if (state == S_XMIT)
                        begin
                            xsum <= xsum ^ rdat;
                            if (c_t2u)
                            begin
                                unit_wr    <= 1'b1;
                                unit_wdata <= rdat;
                            end
                            else
                            begin
                                term_wr    <= 1'b1;
                                term_wdata <= rdat;
                            end
                            if (idx == len - AW'(1))
                            begin
                                state <= S_VER;
                                phase <= PH_VER;
                            end
                        end
                        else
                        begin
                            vsum <= vsum ^ rdat;
                            if (idx == len - AW'(1))
                            begin
                                if ((vsum ^ rdat) != xsum)
                                begin
                                    state    <= S_FAIL;
                                    err_code <= ERR_VERIFY;
                                    phase    <= PH_FAIL;
                                    fail_evt <= 1'b1;
                                end
                                else if (c_sim && !seg)
                                begin
                                    seg   <= 1'b1;          // second data type
                                    state <= S_PREP;
                                    phase <= PH_PREP;
                                end
                                else
                                begin
                                    state    <= S_DONE;
                                    phase    <= PH_DONE;
                                    done_evt <= 1'b1;
                                end
                            end
                        end
                    end
                end
                // terminal states hold until reset
                S_DONE, S_FAIL:
                begin
                    state <= state;
                end
                default:
                begin
                    state <= S_SAMPLE;
                end
            endcase
        end
    end

    // operating status held off while a unit is fitted
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            operating_enable <= 1'b0;
        else
            operating_enable <= !unit_present;
    end

    // manual settings register and start pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl      <= 5'h00;
            start_req <= 1'b0;
        end
        else
        begin
            start_req <= bus_wr && (bus_addr == OFF_CTRL) && bus_wdata[CTRL_START];
            if (bus_wr && (bus_addr == OFF_CTRL))
                ctrl <= {bus_wdata[4:1], 1'b0};
        end
    end

    // sticky events, write one to clear, set wins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_stat <= 2'h0;
            irq_mask <= IRQ_MASK_RST;
            irq      <= 1'b0;
        end
        else
        begin
            irq_stat <= (irq_stat & ~((bus_wr && (bus_addr == OFF_IRQ_ST))
                        ? bus_wdata[1:0] : 2'h0)) | {fail_evt, done_evt};
            if (bus_wr && (bus_addr == OFF_IRQ_MSK))
                irq_mask <= bus_wdata[1:0];
            irq <= |(irq_stat & irq_mask);
        end
    end

    // read data, one cycle after the strobe, zero elsewhere
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            bus_rdata <= 32'h0;
        else if (!bus_rd)
            bus_rdata <= 32'h0;
        else
        begin
            case (bus_addr)
                OFF_CTRL:    bus_rdata <= {27'h0, ctrl};
                OFF_STATUS:  bus_rdata <= {6'h0, unit_present, seg, 3'h0, idx, sw_cap,
                                           1'b0, err_code, 1'b0, phase};
                OFF_IRQ_ST:  bus_rdata <= {30'h0, irq_stat};
                OFF_IRQ_MSK: bus_rdata <= {30'h0, irq_mask};
                default:     bus_rdata <= 32'h0;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_op_block;
        unit_present |=> !operating_enable;
    endproperty
    a_op_block: assert property (p_op_block) else $error("operating with unit fitted");

    property p_mode_err;
        (state == S_CHECK) && unit_present && !one_mode(sw_cap)
            |=> (state == S_FAIL) && (err_code == ERR_MODE) && !term_wr && !unit_wr;
    endproperty
    a_mode_err: assert property (p_mode_err) else $error("mode error missed");

    property p_term_protect;
        term_wr |-> sw_cap[IDX_TERM_WE] && !c_t2u;
    endproperty
    a_term_protect: assert property (p_term_protect) else $error("terminal write");

    property p_unit_protect;
        unit_wr |-> sw_cap[IDX_UNIT_WE] && c_t2u;
    endproperty
    a_unit_protect: assert property (p_unit_protect) else $error("unit write");

    property p_sim_bank;
        unit_wr && c_sim |-> (unit_bank == seg) && (e_sys == !seg);
    endproperty
    a_sim_bank: assert property (p_sim_bank) else $error("wrong bank");

    property p_sample_once;
        (state != S_SAMPLE) |=> $stable(sw_cap);
    endproperty
    a_sample_once: assert property (p_sample_once) else $error("switches resampled");

    property p_sys_area;
        term_wr && (term_area == AREA_SYS)
            |-> unit_bank_is_sys[unit_bank] && unit_sys_compat[unit_bank];
    endproperty
    a_sys_area: assert property (p_sys_area) else $error("bad system write");

    property p_phase_seq;
        (state == S_PREP) && (chk == ERR_NONE) |=> (phase == PH_XMIT) ##1 (phase == PH_XMIT);
    endproperty
    a_phase_seq: assert property (p_phase_seq) else $error("phase wrong");

    property p_cov_done;
        done_evt;
    endproperty
    c_cov_done: cover property (p_cov_done);

    property p_cov_mode;
        err_code == ERR_MODE;
    endproperty
    c_cov_mode: cover property (p_cov_mode);

    property p_cov_sim;
        seg && unit_wr;
    endproperty
    c_cov_sim: cover property (p_cov_sim);

endmodule : mutc_top
`default_nettype wire
